// [src/wdt_timer.sv]
// Watchdog and interval timer with keyed register writes.
`timescale 1ns/1ps

// Summary of operation
// - Counter is eight-bit, readable and writable
// - Enable low stops counter at zero
// - Enable high counts selected prescaled ticks
// - Interval mode wrap sets overflow flag
// - Overflow flag cleared by read-then-zero or by overflow reset
// - Internal overflow reset clears overflow flag
// - Mode zero raises interval interrupt
// - Mode one asserts low overflow output
// - Clock select picks one of eight taps
// - Reserved bits read one, ignore writes
// - External reset loads reset register 1F
// - Watchdog wrap sets watchdog flag only
// - Watchdog flag cleared by read-then-zero
// - Reset enable makes overflow request chip reset
// - Without enable, only own registers reset
// - Spare bit is plain storage, reset zero
// - Registers written only by keyed access
// - Counter/control writes are word, shared address
// - Separate byte read addresses, reset word write
// - Overflow output 132 or 130 states
// - Chip reset request held 518 states
module wdt_timer
  import wdt_pkg::*;
(
  // Clock and external reset pin.
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  // Internal bus.
  input  wire logic [15:0] bus_addr_i,
  input  wire logic        bus_rd_i,
  input  wire logic        bus_wr_i,
  input  wire logic        bus_word_i,
  input  wire logic [15:0] bus_wdata_i,
  output logic      [7:0]  bus_rdata_o,
  // Overflow signalling.
  output logic             overflow_out_n_o,
  output logic             interval_irq_o,
  output logic             chip_reset_req_o
);

  wdt_regs_t q;
  wdt_regs_t d;

  // Reassembles the control/status register as read by software.
  function automatic logic [7:0] ctrl_view(input wdt_regs_t r);
    ctrl_view = WDT_CTRL_ONES;
    ctrl_view[WDT_CTRL_OVF_BIT]  = r.ovf;
    ctrl_view[WDT_CTRL_MODE_BIT] = r.mode;
    ctrl_view[WDT_CTRL_EN_BIT]   = r.en;
    ctrl_view[2:0]               = r.cks;
  endfunction : ctrl_view

  function automatic logic [7:0] rst_view(input wdt_regs_t r);
    rst_view = WDT_RST_ONES;
    rst_view[WDT_RST_WATCHDOG_OVERFLOW_FLAG_BIT]  = r.watchdog_overflow_flag;
    rst_view[WDT_RST_RESET_ON_OVERFLOW_ENABLE_BIT]  = r.reset_on_overflow_enable;
    rst_view[WDT_RST_SPARE_BIT] = r.spare;
  endfunction : rst_view

  // Index of the prescaler bit whose rising edge gives the selected tick.
  function automatic int unsigned tap_bit(input logic [2:0] cks);
    case (cks)
      3'h0:    tap_bit = 0;
      3'h1:    tap_bit = 5;
      3'h2:    tap_bit = 6;
      3'h3:    tap_bit = 8;
      3'h4:    tap_bit = 10;
      3'h5:    tap_bit = 12;
      3'h6:    tap_bit = 14;
      default: tap_bit = 16;
    endcase
  endfunction : tap_bit

  logic                 wr_shared;
  logic                 wr_rst;
  logic [7:0]           key;
  logic [7:0]           low;
  logic                 tick;
  logic [WDT_PRE_W-1:0] pre_next;
  logic                 wrap;
  logic                 locked;

  always_comb
  begin
    d         = q;
    key       = bus_wdata_i[15:8];
    low       = bus_wdata_i[7:0];
    // While the overflow output is low the registers are not writable.
    locked    = (q.st != WDT_ST_RUN);
    wr_shared = bus_wr_i && bus_word_i && (bus_addr_i == WDT_ADDR_CTRL_WR) && !locked;
    wr_rst    = bus_wr_i && bus_word_i && (bus_addr_i == WDT_ADDR_RST_WR) && !locked;

    // Prescaler free-runs only while counting so each start is aligned.
    pre_next  = q.en ? q.pre + 1'b1 : '0;
    tick      = q.en && !q.pre[tap_bit(q.cks)] && pre_next[tap_bit(q.cks)];
    d.pre     = pre_next;
    wrap      = 1'b0;

    if (!q.en)
    begin
      d.count = WDT_COUNT_ZERO;
    end
    else if (tick)
    begin
      d.count = q.count + 1'b1;
      wrap    = (q.count == WDT_COUNT_MAX);
    end

    // Reads: a flag is armed for clearing only when seen set.
    d.rdata = 8'h00;
    if (bus_rd_i)
    begin
      case (bus_addr_i)
        WDT_ADDR_CTRL_RD:
        begin
          d.rdata = ctrl_view(q);
          if (q.ovf)
          begin
            d.ovf_seen = 1'b1;
          end
        end
        WDT_ADDR_COUNT_RD:
        begin
          d.rdata = q.count;
        end
        WDT_ADDR_RST_RD:
        begin
          d.rdata = rst_view(q);
          // A flag read during the overflow pulse is not recognised.
          if (q.watchdog_overflow_flag && !locked)
          begin
            d.watchdog_overflow_flag_seen = 1'b1;
          end
        end
        default:
        begin
          d.rdata = 8'h00;
        end
      endcase
    end

    // Keyed writes; the write wins over a coincident tick, except a watchdog-mode wrap, whose internal reset wins.
    if (wr_shared && key == WDT_KEY_COUNT)
    begin
      d.count = low;
    end
    if (wr_shared && key == WDT_KEY_CTRL)
    begin
      d.mode = low[WDT_CTRL_MODE_BIT];
      d.en   = low[WDT_CTRL_EN_BIT];
      d.cks  = low[2:0];
      if (!low[WDT_CTRL_OVF_BIT] && q.ovf_seen)
      begin
        d.ovf      = 1'b0;
        d.ovf_seen = 1'b0;
      end
    end
    if (wr_rst && key == WDT_KEY_RESET_ON_OVERFLOW_ENABLE)
    begin
      d.reset_on_overflow_enable  = low[WDT_RST_RESET_ON_OVERFLOW_ENABLE_BIT];
      d.spare = low[WDT_RST_SPARE_BIT];
    end
    if (wr_rst && key == WDT_KEY_WATCHDOG_OVERFLOW_FLAG && !low[WDT_RST_WATCHDOG_OVERFLOW_FLAG_BIT] && q.watchdog_overflow_flag_seen)
    begin
      d.watchdog_overflow_flag      = 1'b0;
      d.watchdog_overflow_flag_seen = 1'b0;
    end

    // Overflow events; a set wins over a clear in the same cycle.
    if (wrap && !q.mode)
    begin
      d.ovf = 1'b1;
    end
    if (wrap && q.mode)
    begin
      d.watchdog_overflow_flag = 1'b1;
    end

    case (q.st)
      WDT_ST_RUN:
      begin
        if (wrap && q.mode)
        begin
          d.st      = WDT_ST_PULSE;
          d.ovf_n   = 1'b0;
          d.ovf_cnt = q.reset_on_overflow_enable ? WDT_OVF_CYC_RESET_ON_OVERFLOW_ENABLE - 10'h001 : WDT_OVF_CYC_NORST - 10'h001;
          d.rst_cnt = WDT_CHIP_RST_CYC - 10'h001;
          d.chip_rst = q.reset_on_overflow_enable;
          // Counter and control register reset in both cases.
          d.count    = WDT_COUNT_ZERO;
          d.en       = 1'b0;
          d.mode     = 1'b0;
          d.cks      = 3'h0;
          d.ovf      = 1'b0;
          d.ovf_seen = 1'b0;
          d.pre      = '0;
        end
      end
      WDT_ST_PULSE:
      begin
        d.count = WDT_COUNT_ZERO;
        d.ovf   = 1'b0;
        if (q.ovf_cnt == 10'h000)
        begin
          d.ovf_n = 1'b1;
          d.st    = q.chip_rst ? WDT_ST_HOLD : WDT_ST_RUN;
        end
        else
        begin
          d.ovf_cnt = q.ovf_cnt - 10'h001;
        end
        if (q.chip_rst)
        begin
          d.rst_cnt = q.rst_cnt - 10'h001;
        end
      end
      WDT_ST_HOLD:
      begin
        d.count = WDT_COUNT_ZERO;
        d.ovf   = 1'b0;
        if (q.rst_cnt == 10'h000)
        begin
          d.chip_rst = 1'b0;
          d.st       = WDT_ST_RUN;
        end
        else
        begin
          d.rst_cnt = q.rst_cnt - 10'h001;
        end
      end
      default:
      begin
        d.st = WDT_ST_RUN;
      end
    endcase

    d.irq = d.ovf && !d.mode;
  end

  // Only the external pin resets the reset register; the internal reset does not.
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      q          <= '0;
      q.st       <= WDT_ST_RUN;
      q.watchdog_overflow_flag     <= WDT_RST_RESET[WDT_RST_WATCHDOG_OVERFLOW_FLAG_BIT];
      q.reset_on_overflow_enable     <= WDT_RST_RESET[WDT_RST_RESET_ON_OVERFLOW_ENABLE_BIT];
      q.spare    <= WDT_RST_RESET[WDT_RST_SPARE_BIT];
      q.ovf_n    <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign bus_rdata_o      = q.rdata;
  assign overflow_out_n_o = q.ovf_n;
  assign interval_irq_o   = q.irq;
  assign chip_reset_req_o = q.chip_rst;

endmodule : wdt_timer

// [src/wdt_pkg.sv]
// Package with register layout, key codes and timing constants of the watchdog interval timer.
package wdt_pkg;

  // Byte addresses of the internal bus.
  localparam logic [15:0] WDT_ADDR_CTRL_WR  = 16'hFFBC;
  localparam logic [15:0] WDT_ADDR_CTRL_RD  = 16'hFFBC;
  localparam logic [15:0] WDT_ADDR_COUNT_RD = 16'hFFBD;
  localparam logic [15:0] WDT_ADDR_RST_WR   = 16'hFFBE;
  localparam logic [15:0] WDT_ADDR_RST_RD   = 16'hFFBF;

  // Upper-byte key codes of the keyed word writes; the values are arbitrary.
  localparam logic [7:0] WDT_KEY_COUNT = 8'h5A;
  localparam logic [7:0] WDT_KEY_CTRL  = 8'hA5;
  localparam logic [7:0] WDT_KEY_RESET_ON_OVERFLOW_ENABLE  = 8'h5A;
  localparam logic [7:0] WDT_KEY_WATCHDOG_OVERFLOW_FLAG  = 8'hA5;

  // Field positions of the timer control/status register.
  localparam int WDT_CTRL_OVF_BIT  = 7;
  localparam int WDT_CTRL_MODE_BIT = 6;
  localparam int WDT_CTRL_EN_BIT   = 5;

  // Field positions of the reset control/status register.
  localparam int WDT_RST_WATCHDOG_OVERFLOW_FLAG_BIT  = 7;
  localparam int WDT_RST_RESET_ON_OVERFLOW_ENABLE_BIT  = 6;
  localparam int WDT_RST_SPARE_BIT = 5;

  // Fixed read-as-one patterns and reset values.
  localparam logic [7:0] WDT_CTRL_ONES  = 8'h18;
  localparam logic [7:0] WDT_RST_ONES   = 8'h1F;
  localparam logic [7:0] WDT_RST_RESET  = 8'h1F;
  localparam logic [7:0] WDT_COUNT_ZERO = 8'h00;
  localparam logic [7:0] WDT_COUNT_MAX  = 8'hFF;

  // Pulse lengths in states of the system clock.
  localparam int          WDT_OVF_STATES_RESET_ON_OVERFLOW_ENABLE   = 132;
  localparam int          WDT_OVF_STATES_NORST  = 130;
  localparam int          WDT_CHIP_RST_STATES   = 518;
  localparam logic [9:0]  WDT_OVF_CYC_RESET_ON_OVERFLOW_ENABLE      = 10'(WDT_OVF_STATES_RESET_ON_OVERFLOW_ENABLE);
  localparam logic [9:0]  WDT_OVF_CYC_NORST     = 10'(WDT_OVF_STATES_NORST);
  localparam logic [9:0]  WDT_CHIP_RST_CYC      = 10'(WDT_CHIP_RST_STATES);

  // Prescaler width covering the slowest tap, phi/131072.
  localparam int WDT_PRE_W = 17;

  typedef enum logic [1:0] {
    WDT_ST_RUN   = 2'b00,
    WDT_ST_PULSE = 2'b01,
    WDT_ST_HOLD  = 2'b11
  } wdt_state_t;

  typedef struct packed {
    wdt_state_t           st;
    logic [WDT_PRE_W-1:0] pre;
    logic [7:0]           count;
    logic                 ovf;
    logic                 mode;
    logic                 en;
    logic [2:0]           cks;
    logic                 watchdog_overflow_flag;
    logic                 reset_on_overflow_enable;
    logic                 spare;
    logic                 ovf_seen;
    logic                 watchdog_overflow_flag_seen;
    logic [9:0]           ovf_cnt;
    logic [9:0]           rst_cnt;
    logic                 ovf_n;
    logic                 chip_rst;
    logic                 irq;
    logic [7:0]           rdata;
  } wdt_regs_t;

endpackage : wdt_pkg

// [verification/wdt_timer_properties.sv]
// Port-level checker of the watchdog interval timer.
`timescale 1ns/1ps
module wdt_timer_chk
  import wdt_pkg::*;
(
  input wire logic        ref_clk_i,
  input wire logic        rst_n_i,
  input wire logic [15:0] bus_addr_i,
  input wire logic        bus_rd_i,
  input wire logic        bus_wr_i,
  input wire logic [7:0]  bus_rdata_o,
  input wire logic        overflow_out_n_o,
  input wire logic        interval_irq_o,
  input wire logic        chip_reset_req_o
);
  logic [9:0] lo_q;
  logic [9:0] cr_q;
  // Pulse lengths are counted here, since a repetition of 130 cycles is too long to unroll.
  always_ff @(posedge ref_clk_i)
  begin
    lo_q <= (!rst_n_i || overflow_out_n_o) ? 10'h000 : lo_q + 10'h001;
    cr_q <= (!rst_n_i || !chip_reset_req_o) ? 10'h000 : cr_q + 10'h001;
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_rd_rst;
    bus_rd_i && bus_addr_i == WDT_ADDR_RST_RD ##1 1'b1;
  endsequence
  sequence s_rd_ctrl;
    bus_rd_i && bus_addr_i == WDT_ADDR_CTRL_RD ##1 1'b1;
  endsequence
  sequence s_ovf_start;
    $fell(overflow_out_n_o);
  endsequence
  a_rdata_idle: assert property (!bus_rd_i |=> bus_rdata_o == 8'h00) else $error("read data not idle");
  a_rst_ones: assert property (s_rd_rst |-> bus_rdata_o[4:0] == 5'h1F) else $error("reset reg low bits");
  a_ctrl_ones: assert property (s_rd_ctrl |-> bus_rdata_o[4:3] == 2'b11) else $error("ctrl bits 4:3");
  a_ovf_len: assert property ($rose(overflow_out_n_o) |-> lo_q == (chip_reset_req_o ? 10'd132 : 10'd130))
    else $error("overflow pulse length");
  a_chip_rst_len: assert property ($fell(chip_reset_req_o) |-> cr_q == 10'd518) else $error("chip reset length");
  a_rst_with_ovf: assert property ($rose(chip_reset_req_o) |-> $fell(overflow_out_n_o)) else $error("reset alone");
  a_ovf_hold: assert property (s_ovf_start |-> !overflow_out_n_o [*8]) else $error("overflow pulse short");
  a_irq_clear_wr: assert property ($fell(interval_irq_o) |-> $past(bus_wr_i) || $past(bus_wr_i, 2))
    else $error("irq dropped without write");
  a_irq_quiet: assert property (!overflow_out_n_o |-> !interval_irq_o) else $error("irq in watchdog pulse");
endmodule : wdt_timer_chk

bind wdt_timer wdt_timer_chk i_wdt_timer_chk (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .bus_addr_i(bus_addr_i),
  .bus_rd_i(bus_rd_i), .bus_wr_i(bus_wr_i), .bus_rdata_o(bus_rdata_o), .overflow_out_n_o(overflow_out_n_o),
  .interval_irq_o(interval_irq_o), .chip_reset_req_o(chip_reset_req_o));

// [verification/tb_top.sv]
// Self-checking testbench of the watchdog interval timer.
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb_top
  import wdt_pkg::*;
;
  localparam int DIV [8] = '{2, 64, 128, 512, 2048, 8192, 32768, 131072};
  logic        ref_clk_i;
  logic        rst_n_i;
  logic [15:0] bus_addr_i;
  logic        bus_rd_i;
  logic        bus_wr_i;
  logic        bus_word_i;
  logic [15:0] bus_wdata_i;
  logic [7:0]  bus_rdata_o;
  logic        overflow_out_n_o;
  logic        interval_irq_o;
  logic        chip_reset_req_o;
  int          err_count;
  int          cmp_count;
  int          n_lo;
  int          n_cr;
  logic        sp;
  logic [7:0]  v;

  wdt_timer i_wdt_timer (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .bus_addr_i(bus_addr_i), .bus_rd_i(bus_rd_i),
    .bus_wr_i(bus_wr_i), .bus_word_i(bus_word_i), .bus_wdata_i(bus_wdata_i), .bus_rdata_o(bus_rdata_o),
    .overflow_out_n_o(overflow_out_n_o), .interval_irq_o(interval_irq_o), .chip_reset_req_o(chip_reset_req_o));

  always #5 ref_clk_i = ~ref_clk_i;

  function automatic logic [7:0] rst_exp(input logic watchdog_overflow_flag, input logic reset_on_overflow_enable, input logic spare);
    return {watchdog_overflow_flag, reset_on_overflow_enable, spare, WDT_RST_ONES[4:0]};
  endfunction : rst_exp

  // Only taps up to phi/8192 tick within the wait; slower taps must still read zero.
  function automatic logic [7:0] tick_exp(input int k);
    return (DIV[k] > 8192) ? 8'h00 : 8'h01;
  endfunction : tick_exp

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : cyc

  task automatic wr(input logic [15:0] a, input logic [7:0] k, input logic [7:0] val, input logic w);
    @(posedge ref_clk_i);
    bus_addr_i  <= a;
    bus_wdata_i <= {k, val};
    bus_word_i  <= w;
    bus_wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    bus_wr_i <= 1'b0;
  endtask : wr

  task automatic rc(input logic [15:0] a, input logic [7:0] e, input string n);
    @(posedge ref_clk_i);
    bus_addr_i <= a;
    bus_rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    bus_rd_i <= 1'b0;
    #1;
    `CHK(n, e, bus_rdata_o)
  endtask : rc

  // The window covers the whole overflow pulse and the chip reset hold.
  task automatic pulse();
    n_lo = 0;
    n_cr = 0;
    repeat (700)
    begin
      @(negedge ref_clk_i);
      n_lo += int'(!overflow_out_n_o);
      n_cr += int'(chip_reset_req_o);
    end
  endtask : pulse

  task automatic final_report();
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report

  initial
  begin
    #800000;
    err_count++;
    final_report();
  end

  initial
  begin
    ref_clk_i   = 1'b0;
    rst_n_i     = 1'b0;
    bus_addr_i  = 16'h0000;
    bus_rd_i    = 1'b0;
    bus_wr_i    = 1'b0;
    bus_word_i  = 1'b0;
    bus_wdata_i = 16'h0000;
    err_count   = 0;
    cmp_count   = 0;
    void'($urandom(15));
    cyc(6);
    rst_n_i <= 1'b1;
    rc(WDT_ADDR_RST_RD, 8'h1F, "rst init");
    wr(WDT_ADDR_CTRL_WR, WDT_KEY_CTRL, 8'h20, 1'b1);
    wr(WDT_ADDR_CTRL_WR, WDT_KEY_COUNT, 8'hFE, 1'b1);
    cyc(20);
    `CHK("irq", 1'b1, interval_irq_o)
    rc(WDT_ADDR_CTRL_RD, 8'hB8, "ovf set");
    rc(WDT_ADDR_RST_RD, 8'h1F, "no watchdog_overflow_flag");
    wr(WDT_ADDR_CTRL_WR, WDT_KEY_CTRL, 8'hA0, 1'b1);
    rc(WDT_ADDR_CTRL_RD, 8'hB8, "ovf kept");
    wr(WDT_ADDR_CTRL_WR, WDT_KEY_CTRL, 8'h00, 1'b1);
    cyc(2);
    `CHK("irq clr", 1'b0, interval_irq_o)
    rc(WDT_ADDR_CTRL_RD, 8'h18, "ovf clr");
    rc(WDT_ADDR_COUNT_RD, 8'h00, "stopped");
    wr(WDT_ADDR_CTRL_WR, WDT_KEY_CTRL, 8'h27, 1'b0);
    rc(WDT_ADDR_CTRL_RD, 8'h18, "byte wr");
    wr(WDT_ADDR_CTRL_WR, 8'h33, 8'h27, 1'b1);
    rc(WDT_ADDR_CTRL_RD, 8'h18, "bad key");
    wr(WDT_ADDR_COUNT_RD, WDT_KEY_CTRL, 8'h27, 1'b1);
    rc(WDT_ADDR_CTRL_RD, 8'h18, "bad addr");
    wr(WDT_ADDR_CTRL_WR, WDT_KEY_CTRL, 8'h27, 1'b1);
    repeat (6)
    begin
      v  = 8'($urandom);
      sp = 1'($urandom);
      wr(WDT_ADDR_CTRL_WR, WDT_KEY_COUNT, v, 1'b1);
      rc(WDT_ADDR_COUNT_RD, v, "count");
      wr(WDT_ADDR_RST_WR, WDT_KEY_RESET_ON_OVERFLOW_ENABLE, {2'b00, sp, 5'h00}, 1'b1);
      rc(WDT_ADDR_RST_RD, rst_exp(1'b0, 1'b0, sp), "spare");
    end
    for (int k = 1; k < 8; k++)
    begin
      wr(WDT_ADDR_CTRL_WR, WDT_KEY_CTRL, 8'h00, 1'b1);
      wr(WDT_ADDR_CTRL_WR, WDT_KEY_CTRL, 8'h20 | 8'(k), 1'b1);
      cyc(DIV[k] > 8192 ? 8192 : DIV[k]);
      rc(WDT_ADDR_COUNT_RD, tick_exp(k), "tap");
    end
    wr(WDT_ADDR_CTRL_WR, WDT_KEY_CTRL, 8'h00, 1'b1);
    wr(WDT_ADDR_RST_WR, WDT_KEY_RESET_ON_OVERFLOW_ENABLE, {2'b01, sp, 5'h00}, 1'b1);
    wr(WDT_ADDR_CTRL_WR, WDT_KEY_CTRL, 8'h60, 1'b1);
    wr(WDT_ADDR_CTRL_WR, WDT_KEY_COUNT, 8'hFF, 1'b1);
    pulse();
    `CHK("ovf len", 132, n_lo)
    `CHK("rst len", 518, n_cr)
    rc(WDT_ADDR_RST_RD, rst_exp(1'b1, 1'b1, sp), "watchdog_overflow_flag");
    rc(WDT_ADDR_CTRL_RD, 8'h18, "ctrl wd");
    wr(WDT_ADDR_RST_WR, WDT_KEY_WATCHDOG_OVERFLOW_FLAG, 8'h80, 1'b1);
    rc(WDT_ADDR_RST_RD, rst_exp(1'b1, 1'b1, sp), "watchdog_overflow_flag one");
    wr(WDT_ADDR_RST_WR, WDT_KEY_WATCHDOG_OVERFLOW_FLAG, 8'h00, 1'b1);
    rc(WDT_ADDR_RST_RD, rst_exp(1'b0, 1'b1, sp), "watchdog_overflow_flag clr");
    wr(WDT_ADDR_RST_WR, WDT_KEY_RESET_ON_OVERFLOW_ENABLE, {2'b00, sp, 5'h00}, 1'b1);
    wr(WDT_ADDR_CTRL_WR, WDT_KEY_CTRL, 8'h60, 1'b1);
    wr(WDT_ADDR_CTRL_WR, WDT_KEY_COUNT, 8'hFF, 1'b1);
    pulse();
    `CHK("ovf len", 130, n_lo)
    `CHK("no rst", 0, n_cr)
    rc(WDT_ADDR_RST_RD, rst_exp(1'b1, 1'b0, sp), "watchdog_overflow_flag");
    rc(WDT_ADDR_CTRL_RD, 8'h18, "ctrl wd");
    @(posedge ref_clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    rc(WDT_ADDR_RST_RD, 8'h1F, "rst pin");
    final_report();
  end
endmodule : tb_top
